// ==== hdl/bpmc_top.sv ====
// Top of the battery power mode controller: mode machine, registers, interrupt
// Summary of operation
// - Mission mode whenever system supply good and PLL locked; only metering mode.
// - Supply-good flag clears when comparator reports supply below 2.8 V.
// - Supply lost and flag low forces brownout without processor action.
// - Mission/brownout changes keep processor clocked, never reset it.
// - In brownout, processor may request display-only or sleep via control bits.
// - Brownout disables supply-fed resources: ADC and compute engine.
// - Brownout keeps PLL at mission frequency.
// - Supply return moves any battery mode back to mission.
// - Wake-up on battery enters brownout.
// - Sleep entered only from brownout; display-only from brownout or mission, under processor control.
// - Timer, pushbutton, pin rising edge or receive activity wake to brownout.
// - Cause of each wake-up recorded in readable status.
// - Display-only request in mission gives momentary display mode then wake.
// - Display mode keeps PLL only when boost select equals 10.
`timescale 1ns/1ps
module bpmc_top (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 srst,
  // Avalon-MM slave
  input  wire logic [3:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output      logic [31:0]          avs_readdata,
  output      logic                 avs_waitrequest,
  // Supply and clock status
  input  wire logic                 supply_above_threshold,
  input  wire logic                 pll_locked,
  // Wake sources
  input  wire bpmc_pkg::bpmc_wake_t wake_in,
  // Power gating and status
  output      bpmc_pkg::bpmc_power_t power_en,
  output      bpmc_pkg::bpmc_mode_t  mode,
  output      logic                 system_supply_good,
  output      logic                 irq
);
  import bpmc_pkg::*;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  // One wait cycle on every access keeps read data registered
  logic        ack_r;
  logic [31:0] rdata_r;
  logic [31:0] ctrl_r;
  logic [7:0]  status_r;
  logic [7:0]  mask_r;
  logic        supply_good_r;
  bpmc_mode_t  mode_r;
  bpmc_mode_t  mode_nxt;

  wire req      = avs_read | avs_write;
  wire acc      = req & ack_r;
  wire wr_ctrl  = avs_write & ack_r & (avs_address == BPMC_OFS_CTRL);
  wire wr_stat  = avs_write & ack_r & (avs_address == BPMC_OFS_STATUS);
  wire wr_mask  = avs_write & ack_r & (avs_address == BPMC_OFS_MASK);

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  wire [31:0] ctrl_wr_v = be_merge(ctrl_r, avs_writedata, avs_byteenable);
  wire [31:0] stat_wr_v = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);
  wire [31:0] mask_wr_v = be_merge({24'h00_0000, mask_r}, avs_writedata, avs_byteenable);

  logic [31:0] rd_mux;
  always_comb begin
    unique case (avs_address)
      BPMC_OFS_CTRL:   rd_mux = ctrl_r;
      BPMC_OFS_MODE:   rd_mux = {29'h000_0000, supply_good_r, mode_r};
      BPMC_OFS_STATUS: rd_mux = {24'h00_0000, status_r};
      BPMC_OFS_MASK:   rd_mux = {24'h00_0000, mask_r};
      default:         rd_mux = BPMC_UNMAPPED_RD;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= req & ~ack_r;
      rdata_r <= rd_mux;
    end
  end

  assign avs_waitrequest = req & ~ack_r;
  assign avs_readdata    = rdata_r;

  // ----------------------------------------
  // Supply flag and wake detection
  // ----------------------------------------
  bpmc_wake_t wake_evt;
  bpmc_wake_detect u_wake (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .wake_in  (wake_in),
    .wake_evt (wake_evt)
  );

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      supply_good_r <= 1'b0;
    end else begin
      supply_good_r <= supply_above_threshold;
    end
  end

  wire disp_req  = ctrl_r[BPMC_CTRL_DISP_BIT];
  wire sleep_req = ctrl_r[BPMC_CTRL_SLEEP_BIT];
  wire [1:0] boost_sel = ctrl_r[BPMC_CTRL_BOOST_LSB +: 2];
  wire any_wake  = |wake_evt;
  wire low_mode  = (mode_r == BPMC_DISPLAY) || (mode_r == BPMC_SLEEP);

  // ----------------------------------------
  // Mode machine
  // ----------------------------------------
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      BPMC_MISSION: begin
        if (!supply_good_r) begin
          mode_nxt = BPMC_BROWNOUT;
        end else if (disp_req) begin
          mode_nxt = BPMC_DISPLAY;
        end
      end
      BPMC_BROWNOUT: begin
        if (supply_good_r && pll_locked) begin
          mode_nxt = BPMC_MISSION;
        end else if (sleep_req) begin
          mode_nxt = BPMC_SLEEP;
        end else if (disp_req) begin
          mode_nxt = BPMC_DISPLAY;
        end
      end
      BPMC_DISPLAY, BPMC_SLEEP: begin
        if (supply_good_r && pll_locked) begin
          mode_nxt = BPMC_MISSION;
        end else if (any_wake || supply_good_r) begin
          // Supply up but PLL not locked: wake to brownout until the PLL relocks
          mode_nxt = BPMC_BROWNOUT;
        end
      end
    endcase
  end

  // Request bits self-clear on leaving a low mode so a wake is not re-entered
  wire clr_reqs = low_mode && (mode_nxt != mode_r);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mode_r <= BPMC_BROWNOUT;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_r <= BPMC_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= ctrl_wr_v;
    end else if (clr_reqs) begin
      ctrl_r[BPMC_CTRL_DISP_BIT]  <= 1'b0;
      ctrl_r[BPMC_CTRL_SLEEP_BIT] <= 1'b0;
    end
  end

  // ----------------------------------------
  // Wake cause status and interrupt
  // ----------------------------------------
  wire [6:0] cause = wake_evt & {7{low_mode}};
  wire       fail  = (mode_r == BPMC_MISSION) && (mode_nxt == BPMC_BROWNOUT);
  wire [7:0] set_v = {fail, cause[0], cause[1], cause[2], cause[3], cause[4], cause[5],
                      cause[6]};

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      status_r <= '0;
      mask_r   <= BPMC_MASK_RST;
    end else begin
      // Set wins over write-one-to-clear
      status_r <= (status_r & ~(wr_stat ? stat_wr_v[7:0] : 8'h00)) | set_v;
      if (wr_mask) begin
        mask_r <= mask_wr_v[7:0];
      end
    end
  end

  assign irq = |(status_r & mask_r);

  // ----------------------------------------
  // Power gating
  // ----------------------------------------
  assign power_en.adc_enable       = (mode_r == BPMC_MISSION);
  assign power_en.engine_enable    = (mode_r == BPMC_MISSION);
  assign power_en.pll_enable       = (mode_r == BPMC_MISSION) || (mode_r == BPMC_BROWNOUT) ||
                                     ((mode_r == BPMC_DISPLAY) &&
                                      (boost_sel == BPMC_BOOST_PLL_ON));
  assign power_en.mpu_clock_enable = (mode_r == BPMC_MISSION) ||
                                     (mode_r == BPMC_BROWNOUT);
  assign mode               = mode_r;
  assign system_supply_good = supply_good_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  // ----------------------------------------
  // Check sequences
  // ----------------------------------------
  sequence s_lowmode;
    (mode_r == BPMC_DISPLAY) || (mode_r == BPMC_SLEEP);
  endsequence

  // A wake only counts as a battery wake while the rail is still down
  sequence s_battery_wake;
    s_lowmode ##0 (any_wake && !supply_good_r);
  endsequence

  sequence s_msn_disp;
    (mode_r == BPMC_MISSION) ##0 (supply_good_r && disp_req);
  endsequence

  sequence s_brn_held;
    (mode_r == BPMC_BROWNOUT) ##0 !(supply_good_r && pll_locked);
  endsequence

  sequence s_low_exit;
    s_lowmode ##0 (mode_nxt != mode_r) ##0 !wr_ctrl;
  endsequence

  // ----------------------------------------
  // Mode checks
  // ----------------------------------------
  a_supply_loss_brn: assert property (
    (mode_r == BPMC_MISSION) && !supply_good_r |=> mode_r == BPMC_BROWNOUT)
    else $error("supply loss did not force brownout");
  // Flag is forced low by reset, so the edge after reset is exempt
  a_supply_flag: assert property (
    !$past(srst) |-> supply_good_r == $past(supply_above_threshold))
    else $error("supply flag does not follow comparator");
  a_return_msn: assert property (
    supply_good_r && pll_locked && (mode_r != BPMC_MISSION) |=> mode_r == BPMC_MISSION)
    else $error("no return to mission");
  a_msn_entry: assert property (
    $changed(mode_r) && (mode_r == BPMC_MISSION) |-> $past(supply_good_r) && $past(pll_locked))
    else $error("mission entered without supply and lock");
  a_wake_to_brn: assert property (
    s_battery_wake |=> mode_r == BPMC_BROWNOUT)
    else $error("wake did not enter brownout");
  a_low_entry: assert property (
    $changed(mode_r) && (mode_r == BPMC_SLEEP) |-> $past(mode_r) == BPMC_BROWNOUT)
    else $error("sleep entered from wrong mode");
  a_brn_stays: assert property (
    s_brn_held ##0 !(sleep_req || disp_req) |=> mode_r == BPMC_BROWNOUT)
    else $error("brownout left without cause");
  a_sleep_entry: assert property (
    s_brn_held ##0 sleep_req |=> mode_r == BPMC_SLEEP)
    else $error("sleep request ignored");
  a_disp_entry: assert property (
    s_msn_disp |=> mode_r == BPMC_DISPLAY)
    else $error("display request in mission ignored");
  a_msn_disp_brief: assert property (
    (mode_r == BPMC_DISPLAY) && supply_good_r |=> mode_r != BPMC_DISPLAY)
    else $error("display mode not brief");
  a_req_autoclr: assert property (
    s_low_exit |=> !disp_req && !sleep_req)
    else $error("mode request survived a wake");

  // ----------------------------------------
  // Power and cause checks
  // ----------------------------------------
  a_msn_power: assert property (
    mode_r == BPMC_MISSION |-> power_en.adc_enable && power_en.engine_enable)
    else $error("metering off in mission");
  a_brn_power: assert property (
    mode_r == BPMC_BROWNOUT |->
    !power_en.adc_enable && !power_en.engine_enable && power_en.pll_enable)
    else $error("brownout power gating wrong");
  a_disp_pll: assert property (
    mode_r == BPMC_DISPLAY |-> power_en.pll_enable == (boost_sel == BPMC_BOOST_PLL_ON))
    else $error("display pll wrong");
  a_cpu_clocked: assert property (
    (mode_r == BPMC_MISSION) || (mode_r == BPMC_BROWNOUT) |-> power_en.mpu_clock_enable)
    else $error("processor clock stopped");
  a_cause_rec: assert property (
    s_lowmode ##0 wake_evt.pushbutton |=> status_r[BPMC_ST_PB])
    else $error("pushbutton cause not recorded");
  a_cause_timer: assert property (
    s_lowmode ##0 wake_evt.timer_expired |=> status_r[BPMC_ST_TIMER])
    else $error("timer cause not recorded");
  a_cause_orx: assert property (
    s_lowmode ##0 wake_evt.optical_rx |=> status_r[BPMC_ST_ORX])
    else $error("optical receive cause not recorded");
  a_fail_cause: assert property (
    (mode_r == BPMC_MISSION) && !supply_good_r |=> status_r[BPMC_ST_FAIL])
    else $error("supply fail cause not recorded");

endmodule // bpmc_top

// ==== hdl/bpmc_pkg.sv ====
// Package: register map, fields, modes and structs of the battery power mode controller
package bpmc_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] BPMC_OFS_CTRL   = 4'h0;
  localparam logic [3:0] BPMC_OFS_MODE   = 4'h4;
  localparam logic [3:0] BPMC_OFS_STATUS = 4'h8;
  localparam logic [3:0] BPMC_OFS_MASK   = 4'hC;

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int BPMC_CTRL_DISP_BIT  = 6;
  localparam int BPMC_CTRL_SLEEP_BIT = 7;
  localparam int BPMC_CTRL_BOOST_LSB = 8;
  localparam logic [1:0] BPMC_BOOST_PLL_ON = 2'h2;

  // ----------------------------------------
  // Status / wake cause fields
  // ----------------------------------------
  localparam int BPMC_ST_TIMER = 0;
  localparam int BPMC_ST_PB    = 1;
  localparam int BPMC_ST_PIN_A = 2;
  localparam int BPMC_ST_PIN_B = 3;
  localparam int BPMC_ST_PIN_C = 4;
  localparam int BPMC_ST_RX    = 5;
  localparam int BPMC_ST_ORX   = 6;
  localparam int BPMC_ST_FAIL  = 7;
  localparam int BPMC_ST_W     = 8;

  localparam logic [31:0] BPMC_CTRL_RST   = 32'h0000_0000;
  localparam logic [7:0]  BPMC_MASK_RST   = 8'h00;
  localparam logic [31:0] BPMC_UNMAPPED_RD = 32'h0000_0000;

  typedef enum logic [1:0] {
    BPMC_MISSION, BPMC_BROWNOUT, BPMC_DISPLAY, BPMC_SLEEP
  } bpmc_mode_t;

  typedef struct packed {
    logic timer_expired;
    logic pushbutton;
    logic pin_a;
    logic pin_b;
    logic pin_c;
    logic serial_rx;
    logic optical_rx;
  } bpmc_wake_t;

  typedef struct packed {
    logic adc_enable;
    logic engine_enable;
    logic pll_enable;
    logic mpu_clock_enable;
  } bpmc_power_t;

endpackage

// ==== hdl/bpmc_wake_detect.sv ====
// Wake source detector: edge detection on wake pins, activity on receive inputs
`timescale 1ns/1ps
module bpmc_wake_detect (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                srst,
  // Raw wake inputs
  input  wire bpmc_pkg::bpmc_wake_t wake_in,
  // Detected events, one cycle per edge or toggle; the timer event follows its input for as long as it is high
  output      bpmc_pkg::bpmc_wake_t wake_evt
);
  import bpmc_pkg::*;

  bpmc_wake_t prev_r;
  bpmc_wake_t evt_r;
  bpmc_wake_t evt_nxt;

  // Pins and pushbutton wake on a rising edge; receive lines idle high, so any toggle
  // counts as activity. The timer is already a pulse source.
  assign evt_nxt.timer_expired = wake_in.timer_expired;
  assign evt_nxt.pushbutton    = wake_in.pushbutton & ~prev_r.pushbutton;
  assign evt_nxt.pin_a         = wake_in.pin_a & ~prev_r.pin_a;
  assign evt_nxt.pin_b         = wake_in.pin_b & ~prev_r.pin_b;
  assign evt_nxt.pin_c         = wake_in.pin_c & ~prev_r.pin_c;
  assign evt_nxt.serial_rx     = wake_in.serial_rx ^ prev_r.serial_rx;
  assign evt_nxt.optical_rx    = wake_in.optical_rx ^ prev_r.optical_rx;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      // Receive lines rest high; a zero history would fake activity after reset
      prev_r <= '{serial_rx: 1'b1, optical_rx: 1'b1, default: 1'b0};
      evt_r  <= '0;
    end else begin
      prev_r <= wake_in;
      evt_r  <= evt_nxt;
    end
  end

  assign wake_evt = evt_r;

endmodule // bpmc_wake_detect

// ==== tb/bpmc_supply_model.sv ====
// Supply comparator and PLL lock model facing the mode controller
`timescale 1ns/1ps
module bpmc_supply_model #(
  parameter int LOCK_CYC = 4
) (
  // Clock
  input  wire logic ref_clk,
  // Rail level from the testbench, PLL enable from the controller
  input  wire logic supply_on,
  input  wire logic pll_en,
  // Status towards the controller
  output      logic supply_above_threshold,
  output      logic pll_locked
);
  int unsigned cnt = 0;

  // Comparator output low whenever the rail is under threshold
  assign supply_above_threshold = supply_on;
  // Lock is lost at the first clock edge after disable, regained only after settling
  always @(posedge ref_clk) begin
    cnt <= (supply_on && pll_en) ? ((cnt < LOCK_CYC) ? cnt + 1 : cnt) : 0;
  end
  assign pll_locked = (cnt == LOCK_CYC);
endmodule // bpmc_supply_model

// ==== tb/tb_battery_power_mode_controller.sv ====
// Self-checking testbench of the battery power mode controller
`timescale 1ns/1ps
module tb_battery_power_mode_controller;
  import bpmc_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        supply_on = 1'b0;
  logic        supply_above_threshold;
  logic        pll_locked;
  bpmc_wake_t  wake_in = 7'h03; // Receive lines idle high
  bpmc_power_t power_en;
  bpmc_mode_t  mode;
  logic        system_supply_good;
  logic        irq;
  logic [31:0] exp_q[$];
  logic [31:0] rnd;
  logic [1:0]  boost;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  localparam logic [31:0] MODE_MSN = 32'h0000_0004;
  localparam logic [31:0] MODE_BRN = 32'h0000_0001;

  bpmc_top dut (
    .ref_clk                (ref_clk),
    .srst                   (srst),
    .avs_address            (avs_address),
    .avs_read               (avs_read),
    .avs_write              (avs_write),
    .avs_writedata          (avs_writedata),
    .avs_byteenable         (4'hF),
    .avs_readdata           (avs_readdata),
    .avs_waitrequest        (avs_waitrequest),
    .supply_above_threshold (supply_above_threshold),
    .pll_locked             (pll_locked),
    .wake_in                (wake_in),
    .power_en               (power_en),
    .mode                   (mode),
    .system_supply_good     (system_supply_good),
    .irq                    (irq)
  );
  bpmc_supply_model partner (
    .ref_clk                (ref_clk),
    .supply_on              (supply_on),
    .pll_en                 (power_en.pll_enable),
    .supply_above_threshold (supply_above_threshold),
    .pll_locked             (pll_locked)
  );

  initial forever #10 ref_clk = ~ref_clk;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic fail(input string msg);
    mismatches++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask
  // One idle edge first, so back-to-back calls never reassign in one step
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic chk_rd(input logic [31:0] e);
    samples_checked++;
    if (avs_readdata !== e) fail($sformatf("read %h expected %h", avs_readdata, e));
  endtask
  task automatic chk_sig(input logic [3:0] got, input logic [3:0] m, input logic [3:0] e);
    samples_checked++;
    if ((got & m) !== (e & m)) fail($sformatf("output %h expected %h", got & m, e & m));
  endtask
  // ----------------------------------------
  // Monitor and timeout
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) fail("read without expectation");
      else chk_rd(exp_q.pop_front());
    end
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail("timeout");
      wrap_up();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h3755));
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    rd(BPMC_OFS_CTRL, BPMC_CTRL_RST);
    rd(BPMC_OFS_MODE, MODE_BRN);
    rd(BPMC_OFS_STATUS, 32'h0000_0000);
    bus(1'b1, 4'h2, 32'hFFFF_FFFF);
    rd(4'h2, BPMC_UNMAPPED_RD);
    supply_on <= 1'b1;
    repeat (12) @(posedge ref_clk);
    rd(BPMC_OFS_MODE, MODE_MSN);
    chk_sig(power_en, 4'hF, 4'hF);
    chk_sig({2'b00, mode}, 4'h3, {2'b00, BPMC_MISSION});
    chk_sig({3'b000, system_supply_good}, 4'h1, 4'h1);
    rnd = $urandom;
    bus(1'b1, BPMC_OFS_MASK, rnd);
    rd(BPMC_OFS_MASK, {24'h00_0000, rnd[7:0]});
    bus(1'b1, BPMC_OFS_MASK, 32'h0000_0080);
    // Supply loss: brownout, gating, sticky fail cause and interrupt
    supply_on <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk_sig(power_en, 4'hC, 4'h0);
    chk_sig(power_en, 4'h3, 4'h3);
    chk_sig({2'b00, mode}, 4'h3, {2'b00, BPMC_BROWNOUT});
    chk_sig({3'b000, system_supply_good}, 4'h1, 4'h0);
    rd(BPMC_OFS_MODE, MODE_BRN);
    rd(BPMC_OFS_STATUS, 32'h0000_0080);
    chk_sig({3'b000, irq}, 4'h1, 4'h1);
    bus(1'b1, BPMC_OFS_STATUS, 32'h0000_0080);
    // Clear lands at the answering edge; irq follows at once and is checked one edge later
    @(posedge ref_clk);
    chk_sig({3'b000, irq}, 4'h1, 4'h0);
    // Every wake source, alternating display and sleep entry
    for (int i = 0; i < 7; i++) begin
      boost = 2'($urandom_range(3));
      bus(1'b1, BPMC_OFS_CTRL, {22'h00_0000, boost, i[0], ~i[0], 6'h00});
      repeat (4) @(posedge ref_clk);
      rd(BPMC_OFS_MODE, i[0] ? 32'h0000_0003 : 32'h0000_0002);
      if (!i[0]) chk_sig({3'b000, power_en.pll_enable}, 4'h1,
                         {3'b000, boost == BPMC_BOOST_PLL_ON});
      // Pins rise from low; receive lines toggle away from their high idle
      wake_in[i] <= ~wake_in[i];
      repeat (4) @(posedge ref_clk);
      wake_in[i] <= ~wake_in[i];
      rd(BPMC_OFS_MODE, MODE_BRN);
      // Status holds optical receive at bit 6 down to the timer at bit 0
      rd(BPMC_OFS_STATUS, 32'h0000_0040 >> i);
      bus(1'b1, BPMC_OFS_STATUS, 32'h0000_00FF);
    end
    // Display request in mission only flickers
    supply_on <= 1'b1;
    repeat (12) @(posedge ref_clk);
    bus(1'b1, BPMC_OFS_CTRL, 32'h0000_0040);
    repeat (12) @(posedge ref_clk);
    rd(BPMC_OFS_MODE, MODE_MSN);
    // Supply return out of sleep, through brownout while the PLL relocks
    supply_on <= 1'b0;
    repeat (4) @(posedge ref_clk);
    bus(1'b1, BPMC_OFS_CTRL, 32'h0000_0080);
    repeat (4) @(posedge ref_clk);
    rd(BPMC_OFS_MODE, 32'h0000_0003);
    supply_on <= 1'b1;
    repeat (12) @(posedge ref_clk);
    rd(BPMC_OFS_MODE, MODE_MSN);
    // Firmware soft reset after the return to mission
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    rd(BPMC_OFS_CTRL, BPMC_CTRL_RST);
    rd(BPMC_OFS_STATUS, 32'h0000_0000);
    repeat (12) @(posedge ref_clk);
    rd(BPMC_OFS_MODE, MODE_MSN);
    wrap_up();
  end
endmodule // tb_battery_power_mode_controller
